// >>> hw/bbie_pkg.sv
// Package of constants and types for the byte and bit instruction executor.
package bbie_pkg;

   ////////////////////////////////////////////////////////////////////////////////
   // Bus geometry and register byte offsets.
   localparam int BBIE_ADDR_W = 5;
   localparam logic [4:0] BBIE_OFF_INSTR = 5'h00;
   localparam logic [4:0] BBIE_OFF_ACC = 5'h04;
   localparam logic [4:0] BBIE_OFF_STATUS = 5'h08;
   localparam logic [4:0] BBIE_OFF_CYCLES = 5'h0c;
   localparam logic [4:0] BBIE_OFF_FADDR = 5'h10;
   localparam logic [4:0] BBIE_OFF_FDATA = 5'h14;

   ////////////////////////////////////////////////////////////////////////////////
   // Status field positions and reset values.
   localparam int BBIE_ST_CARRY = 0;
   localparam int BBIE_ST_HALF = 1;
   localparam int BBIE_ST_ZERO = 2;
   localparam int BBIE_ST_SKIP = 3;
   localparam logic [7:0] BBIE_ACC_RST = 8'h00;
   localparam logic [13:0] BBIE_INSTR_RST = 14'h0000;

   ////////////////////////////////////////////////////////////////////////////////
   // Opcode field layout and match patterns.
   localparam int BBIE_FILE_DEPTH = 128;
   localparam logic [5:0] BBIE_OP_ADD_FILE = 6'h07;
   localparam logic [5:0] BBIE_OP_AND_FILE = 6'h05;
   localparam logic [5:0] BBIE_OP_AND_LIT = 6'h1b;
   localparam logic [4:0] BBIE_OP_BIT_CLR = 5'h08;
   localparam logic [4:0] BBIE_OP_BIT_SET = 5'h09;
   localparam logic [4:0] BBIE_OP_BIT_TST = 5'h0a;

   // One decoded opcode.
   typedef struct packed {
      logic [5:0] major;
      logic [4:0] bit_major;
      logic dest_file;
      logic [6:0] byte_addr;
      logic [2:0] bit_idx;
      logic [5:0] bit_addr;
      logic [7:0] literal;
   } bbie_dec_t;

   // Flag set carried between the executor and the status register.
   typedef struct packed {
      logic skip;
      logic zero;
      logic half;
      logic carry;
   } bbie_flags_t;

endpackage : bbie_pkg

// >>> hw/bbie_core.sv
// Executor for add, AND, bit clear, bit set and bit-test-skip instructions.
//
// Overview of operation
// - Opcode 00 0111 adds accumulator and file register, updates carry, half, zero.
// - Destination bit 0 writes the accumulator, 1 writes the file register.
// - Byte operations use a 7-bit file address, 00h to 7Fh, plus destination.
// - Opcode 01 1011 ANDs accumulator with literal into accumulator, zero only.
// - Opcode 00 0101 ANDs accumulator with file register, routed by destination.
// - Bit operations use a 3-bit bit index and a 6-bit address.
// - Opcode 01 000 clears the chosen file bit in one cycle, flags kept.
// - Opcode 01 001 sets the chosen file bit in one cycle, flags kept.
// - Opcode 01 010 with the bit set continues normally, flags kept.
// - With the tested bit clear the next instruction becomes a no-operation.
// - Bit test takes one cycle without skip, two with skip taken.
`timescale 1ns/10ps

module bbie_core
   import bbie_pkg::*;
(
   // Clock and reset.
   input wire logic clk_in,
   input wire logic arst_n_in,
   // Avalon-MM slave.
   input wire logic [BBIE_ADDR_W-1:0] avs_address_in,
   input wire logic avs_read_in,
   input wire logic avs_write_in,
   input wire logic [31:0] avs_writedata_in,
   output logic [31:0] avs_readdata_out,
   output logic avs_waitrequest_out
);

   ////////////////////////////////////////////////////////////////////////////////
   // State.
   logic [7:0] acc_reg;
   bbie_flags_t flags_reg;
   logic [13:0] instr_reg;
   logic [31:0] cycles_reg;
   logic [6:0] faddr_reg;
   logic [7:0] file_mem [BBIE_FILE_DEPTH];
   logic [31:0] rdata_reg;
   logic rd_done_reg;

   // Zero test shared by every zero-flag update.
   function automatic logic bbie_is_zero(input logic [7:0] v);
      return v == 8'h00;
   endfunction : bbie_is_zero

   // Field split of an opcode.
   function automatic bbie_dec_t bbie_decode(input logic [13:0] op);
      bbie_dec_t d;
      d.major = op[13:8];
      d.bit_major = op[13:9];
      d.dest_file = op[7];
      d.byte_addr = op[6:0];
      // The bit index sits directly above the six-bit address, below the bit opcode.
      d.bit_idx = op[8:6];
      d.bit_addr = op[5:0];
      d.literal = op[7:0];
      return d;
   endfunction : bbie_decode

   ////////////////////////////////////////////////////////////////////////////////
   // Bus decode and the issued instruction.
   logic wr_instr;
   logic wr_acc;
   logic wr_status;
   logic wr_faddr;
   logic wr_fdata;
   bbie_dec_t dec;
   logic is_add;
   logic is_andf;
   logic is_andl;
   logic is_bclr;
   logic is_bset;
   logic is_btst;
   logic [7:0] byte_opnd;
   logic [7:0] bit_opnd;
   logic test_bit;
   logic [8:0] sum9;
   logic [4:0] sum_lo;
   logic [7:0] and_res;

   assign wr_instr = avs_write_in && avs_address_in == BBIE_OFF_INSTR;
   assign wr_acc = avs_write_in && avs_address_in == BBIE_OFF_ACC;
   assign wr_status = avs_write_in && avs_address_in == BBIE_OFF_STATUS;
   assign wr_faddr = avs_write_in && avs_address_in == BBIE_OFF_FADDR;
   assign wr_fdata = avs_write_in && avs_address_in == BBIE_OFF_FDATA;
   assign dec = bbie_decode(avs_writedata_in[13:0]);

   // An instruction issued while a skip is pending is discarded as a no_operation.
   assign is_add = wr_instr && !flags_reg.skip && dec.major == BBIE_OP_ADD_FILE;
   assign is_andf = wr_instr && !flags_reg.skip && dec.major == BBIE_OP_AND_FILE;
   assign is_andl = wr_instr && !flags_reg.skip && dec.major == BBIE_OP_AND_LIT;
   assign is_bclr = wr_instr && !flags_reg.skip && dec.bit_major == BBIE_OP_BIT_CLR;
   assign is_bset = wr_instr && !flags_reg.skip && dec.bit_major == BBIE_OP_BIT_SET;
   assign is_btst = wr_instr && !flags_reg.skip && dec.bit_major == BBIE_OP_BIT_TST;

   // Operands; bit operations reach only the lower 64 file locations.
   assign byte_opnd = file_mem[dec.byte_addr];
   assign bit_opnd = file_mem[{1'b0, dec.bit_addr}];
   assign test_bit = bit_opnd[dec.bit_idx];
   assign sum9 = {1'b0, acc_reg} + {1'b0, byte_opnd};
   assign sum_lo = {1'b0, acc_reg[3:0]} + {1'b0, byte_opnd[3:0]};
   assign and_res = acc_reg & (is_andl ? dec.literal : byte_opnd);

   ////////////////////////////////////////////////////////////////////////////////
   // Accumulator: destination 0 results, literal AND, or a bus write.
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         acc_reg <= BBIE_ACC_RST;
      end else if (is_add && !dec.dest_file) begin
         acc_reg <= sum9[7:0];
      end else if (is_andl || (is_andf && !dec.dest_file)) begin
         acc_reg <= and_res;
      end else if (wr_acc) begin
         acc_reg <= avs_writedata_in[7:0];
      end
   end

   // File registers: destination 1 results, bit clear and set, or a bus write.
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         for (int i = 0; i < BBIE_FILE_DEPTH; i++) begin
            file_mem[i] <= 8'h00;
         end
      end else if (is_add && dec.dest_file) begin
         file_mem[dec.byte_addr] <= sum9[7:0];
      end else if (is_andf && dec.dest_file) begin
         file_mem[dec.byte_addr] <= and_res;
      end else if (is_bclr || is_bset) begin
         file_mem[{1'b0, dec.bit_addr}][dec.bit_idx] <= is_bset;
      end else if (wr_fdata) begin
         file_mem[faddr_reg] <= avs_writedata_in[7:0];
      end
   end

   // Flags; bit operations leave carry, half carry and zero alone.
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         flags_reg <= '0;
      end else if (wr_instr) begin
         if (is_add) begin
            flags_reg.carry <= sum9[8];
            flags_reg.half <= sum_lo[4];
            flags_reg.zero <= bbie_is_zero(sum9[7:0]);
         end else if (is_andf || is_andl) begin
            flags_reg.zero <= bbie_is_zero(and_res);
         end
         // A pending skip is consumed; a clear test bit arms the next one.
         flags_reg.skip <= is_btst && !test_bit;
      end else if (wr_status) begin
         flags_reg <= avs_writedata_in[3:0];
      end
   end

   // Last opcode and retired cycles; a discarded slot counts as one more cycle.
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         instr_reg <= BBIE_INSTR_RST;
         cycles_reg <= 32'h0000_0000;
      end else if (wr_instr) begin
         instr_reg <= avs_writedata_in[13:0];
         cycles_reg <= cycles_reg + 32'h0000_0001;
      end
   end

   // File address pointer for bus access to the file registers.
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         faddr_reg <= 7'h00;
      end else if (wr_faddr) begin
         faddr_reg <= avs_writedata_in[6:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Reads take two cycles so read data always leaves a flip-flop.
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         rdata_reg <= 32'h0000_0000;
         rd_done_reg <= 1'b0;
      end else if (avs_read_in && !rd_done_reg) begin
         rd_done_reg <= 1'b1;
         case (avs_address_in)
            BBIE_OFF_INSTR: rdata_reg <= {18'h0, instr_reg};
            BBIE_OFF_ACC: rdata_reg <= {24'h000000, acc_reg};
            BBIE_OFF_STATUS: rdata_reg <= {28'h0000000, flags_reg};
            BBIE_OFF_CYCLES: rdata_reg <= cycles_reg;
            BBIE_OFF_FADDR: rdata_reg <= {25'h0, faddr_reg};
            BBIE_OFF_FDATA: rdata_reg <= {24'h000000, file_mem[faddr_reg]};
            default: rdata_reg <= 32'h0000_0000;
         endcase
      end else begin
         rd_done_reg <= 1'b0;
      end
   end

   assign avs_readdata_out = rdata_reg;
   assign avs_waitrequest_out = avs_read_in && !rd_done_reg;

   ////////////////////////////////////////////////////////////////////////////////
   // Checks.
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!arst_n_in);

   // Expected results are rebuilt from the raw bus word, not from the datapath nets,
   // so a wrong operand select or field split in the executor shows up here.
   logic [7:0] exp_fopnd;
   logic [7:0] exp_sum;
   logic [7:0] exp_and;
   assign exp_fopnd = file_mem[avs_writedata_in[6:0]];
   assign exp_sum = acc_reg + exp_fopnd;
   assign exp_and = acc_reg & (is_andl ? avs_writedata_in[7:0] : exp_fopnd);

   // A clear tested bit arms the skip for the following issue.
   sequence s_skip_armed;
      is_btst && !test_bit;
   endsequence

   // An issue that arrives while a skip is pending and must be discarded.
   sequence s_discard_issue;
      wr_instr && flags_reg.skip;
   endsequence

   // A bit clear or bit set that reaches the file registers.
   sequence s_bit_write;
      is_bclr || is_bset;
   endsequence

   // Byte operations: addition and AND with a file operand, routed by destination.
   a_add_to_acc: assert property (is_add && !dec.dest_file |=>
      acc_reg == $past(exp_sum) && flags_reg.zero == (acc_reg == 8'h00))
      else $error("add result missing from accumulator");
   a_add_to_file: assert property (is_add && dec.dest_file |=>
      acc_reg == $past(acc_reg) && file_mem[$past(dec.byte_addr)] == $past(exp_sum))
      else $error("add with file destination misrouted");
   a_add_carry: assert property (is_add |=>
      flags_reg.carry == $past(sum9[8]) && flags_reg.half == $past(sum_lo[4]))
      else $error("add carry flags wrong");
   a_and_file_zero: assert property (is_andf |=> $stable(flags_reg.carry) &&
      flags_reg.zero == ($past(exp_and) == 8'h00))
      else $error("file AND flags wrong");
   a_and_to_acc: assert property (is_andf && !dec.dest_file |=>
      acc_reg == $past(exp_and) && file_mem[$past(dec.byte_addr)] == $past(exp_fopnd))
      else $error("file AND with accumulator destination misrouted");
   a_and_to_file: assert property (is_andf && dec.dest_file |=>
      acc_reg == $past(acc_reg) && file_mem[$past(dec.byte_addr)] == $past(exp_and))
      else $error("file AND with file destination misrouted");

   // Literal AND touches only the accumulator and the zero flag.
   a_and_lit_acc: assert property (is_andl |=> acc_reg == $past(exp_and) &&
      $stable(flags_reg.carry) && $stable(flags_reg.half))
      else $error("literal AND wrong");
   a_and_lit_zero: assert property (is_andl |=>
      flags_reg.zero == (acc_reg == 8'h00) && !flags_reg.skip)
      else $error("literal AND zero flag wrong");

   // Bit operations change one file bit and nothing else.
   a_bit_clear: assert property (is_bclr |=>
      !file_mem[{1'b0, $past(dec.bit_addr)}][$past(dec.bit_idx)] && $stable(flags_reg.zero))
      else $error("bit clear failed");
   a_bit_set: assert property (is_bset |=>
      file_mem[{1'b0, $past(dec.bit_addr)}][$past(dec.bit_idx)] && $stable(flags_reg.carry))
      else $error("bit set failed");
   a_bit_clear_byte: assert property (is_bclr |=>
      file_mem[{1'b0, $past(dec.bit_addr)}] ==
      ($past(bit_opnd) & ~(8'h01 << $past(dec.bit_idx))))
      else $error("bit clear disturbed other bits");
   a_bit_set_byte: assert property (is_bset |=>
      file_mem[{1'b0, $past(dec.bit_addr)}] ==
      ($past(bit_opnd) | (8'h01 << $past(dec.bit_idx))))
      else $error("bit set disturbed other bits");
   a_bit_keeps_state: assert property (s_bit_write |=>
      $stable(acc_reg) && $stable(flags_reg))
      else $error("bit operation changed accumulator or flags");

   // Bit test: a set bit continues, a clear bit discards exactly one following issue.
   a_test_no_skip: assert property (is_btst && test_bit |=> !flags_reg.skip &&
      $stable(flags_reg.zero))
      else $error("bit test skipped on a set bit");
   a_test_keeps: assert property (is_btst |=> $stable(acc_reg) &&
      $stable(flags_reg.carry) && $stable(flags_reg.half))
      else $error("bit test changed accumulator or flags");
   a_skip_arm: assert property (s_skip_armed |=> flags_reg.skip)
      else $error("clear tested bit did not arm a skip");
   a_skip_discard: assert property (s_discard_issue |=>
      $stable(acc_reg) && $stable(flags_reg.zero) && !flags_reg.skip)
      else $error("skipped instruction was executed");
   a_skip_once: assert property (wr_instr && !(is_btst && !test_bit) |=>
      !flags_reg.skip)
      else $error("skip stayed armed past one issue");

   // Every issue, discarded or not, is one instruction cycle.
   a_cycle_count: assert property (wr_instr |=> cycles_reg == $past(cycles_reg) + 1)
      else $error("cycle count did not advance");
   a_cycle_hold: assert property (!wr_instr |=> $stable(cycles_reg))
      else $error("cycle count moved without an issue");

endmodule : bbie_core

// >>> verification/bbie_core_test.sv
// Self-checking testbench for the byte and bit instruction executor.
`timescale 1ns/10ps

module bbie_core_test;
   import bbie_pkg::*;

   ////////////////////////////////////////////////////////////////////////////////
   // Design ports, reference state and counters.
   logic clk_in;
   logic arst_n_in;
   logic avs_read_in;
   logic avs_write_in;
   logic [BBIE_ADDR_W-1:0] avs_address_in;
   logic [31:0] avs_writedata_in;
   logic [31:0] avs_readdata_out;
   logic avs_waitrequest_out;
   logic [31:0] rng;
   logic [31:0] rd_data;
   logic [7:0] fm [0:127];
   logic [7:0] m_acc;
   logic [7:0] m_cyc;
   logic m_c, m_h, m_z, m_skip;
   int n_mismatch = 0;
   int n_compared = 0;
   int cyc = 0;

   bbie_core DUT (
      .clk_in(clk_in),
      .arst_n_in(arst_n_in),
      .avs_address_in(avs_address_in),
      .avs_read_in(avs_read_in),
      .avs_write_in(avs_write_in),
      .avs_writedata_in(avs_writedata_in),
      .avs_readdata_out(avs_readdata_out),
      .avs_waitrequest_out(avs_waitrequest_out)
   );

   // Free-running core clock at 250 MHz.
   initial begin
      clk_in = 1'b0;
      forever #2 clk_in = ~clk_in;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Helpers: random source, comparison, bus cycle and closing report.
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] v;
      v = s ^ (s << 13);
      v = v ^ (v >> 17);
      return v ^ (v << 5);
   endfunction : xs

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("MISMATCH %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   // The request is held until waitrequest is low at a rising edge; a hang is cut by the
   // timeout. Waitrequest and read data are looked at mid-cycle, where they are settled,
   // so the edge that samples them is never raced; the request completes at the next edge.
   task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
      @(posedge clk_in);
      avs_address_in <= a;
      avs_write_in <= wr;
      avs_read_in <= ~wr;
      avs_writedata_in <= d;
      @(negedge clk_in);
      while (avs_waitrequest_out !== 1'b0) @(negedge clk_in);
      rd_data = avs_readdata_out;
      @(posedge clk_in);
      avs_write_in <= 1'b0;
      avs_read_in <= 1'b0;
   endtask : bus

   task automatic rd_chk(input logic [4:0] a, input logic [31:0] exp, input string name);
      bus(1'b0, a, 32'h0);
      check(name, rd_data, exp);
   endtask : rd_chk

   task automatic end_sim;
      $display("compared %0d mismatches %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : end_sim

   // Generous ceiling: a full run needs well under ten thousand cycles.
   always @(posedge clk_in) begin
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         n_mismatch++;
         end_sim();
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Reference model; a pending skip swallows the next issue but still costs a cycle.
   task automatic model(input logic [13:0] op, input logic [6:0] fa);
      logic [7:0] f;
      logic [8:0] s;
      logic [4:0] hs;
      f = fm[fa];
      m_cyc = m_cyc + 8'h01;
      s = (op[13:8] == 6'h07) ? {1'b0, m_acc} + {1'b0, f} : {1'b0, m_acc & f};
      hs = {1'b0, m_acc[3:0]} + {1'b0, f[3:0]};
      if (m_skip) m_skip = 1'b0;
      else if (op[13:8] == 6'h07 || op[13:8] == 6'h05) begin
         if (op[13:8] == 6'h07) m_c = s[8];
         if (op[13:8] == 6'h07) m_h = hs[4];
         m_z = (s[7:0] == 8'h00);
         if (op[7]) fm[fa] = s[7:0];
         else m_acc = s[7:0];
      end else if (op[13:8] == 6'h1b) begin
         m_acc = m_acc & op[7:0];
         m_z = (m_acc == 8'h00);
      end else if (op[13:9] == 5'h08) fm[fa][op[8:6]] = 1'b0;
      else if (op[13:9] == 5'h09) fm[fa][op[8:6]] = 1'b1;
      else if (op[13:9] == 5'h0a) m_skip = ~f[op[8:6]];
   endtask : model

   // Load accumulator and target byte, issue one opcode, then compare accumulator, status, target byte and cycle count.
   task automatic run(input logic [13:0] op, input logic [7:0] fv, input logic [7:0] av);
      logic [6:0] fa;
      fa = (op[13:12] == 2'b01) ? {1'b0, op[5:0]} : op[6:0];
      bus(1'b1, BBIE_OFF_ACC, {24'h0, av});
      bus(1'b1, BBIE_OFF_FADDR, {25'h0, fa});
      bus(1'b1, BBIE_OFF_FDATA, {24'h0, fv});
      m_acc = av;
      fm[fa] = fv;
      model(op, fa);
      bus(1'b1, BBIE_OFF_INSTR, {18'h0, op});
      rd_chk(BBIE_OFF_ACC, {24'h0, m_acc}, "acc");
      rd_chk(BBIE_OFF_STATUS, {28'h0, m_skip, m_z, m_h, m_c}, "status");
      rd_chk(BBIE_OFF_FDATA, {24'h0, fm[fa]}, "file");
      bus(1'b0, BBIE_OFF_CYCLES, 32'h0);
      check("cycles", {24'h0, rd_data[7:0]}, {24'h0, m_cyc});
   endtask : run

   ////////////////////////////////////////////////////////////////////////////////
   // Main sequence: reset values, corner cases, then seeded random opcodes.
   initial begin
      logic [13:0] op;
      arst_n_in = 1'b0;
      avs_read_in = 1'b0;
      avs_write_in = 1'b0;
      avs_address_in = 5'h00;
      avs_writedata_in = 32'h0;
      rng = 32'h1513;
      {m_acc, m_cyc, m_c, m_h, m_z, m_skip} = 20'h0;
      for (int i = 0; i < 128; i++) fm[i] = 8'h00;
      repeat (8) @(posedge clk_in);
      arst_n_in <= 1'b1;
      rd_chk(BBIE_OFF_ACC, 32'h0, "acc_rst");
      rd_chk(BBIE_OFF_STATUS, 32'h0, "status_rst");
      rd_chk(BBIE_OFF_CYCLES, 32'h0, "cycles_rst");
      bus(1'b1, 5'h18, 32'hffffffff);
      rd_chk(5'h18, 32'h0, "unmapped");
      run({6'h07, 1'b0, 7'h7f}, 8'hc2, 8'h17);
      run({6'h07, 1'b1, 7'h00}, 8'h01, 8'hff);
      run({6'h07, 1'b0, 7'h05}, 8'h08, 8'h08);
      run({6'h05, 1'b1, 7'h40}, 8'hc2, 8'h17);
      run({6'h1b, 8'h5f}, 8'h00, 8'ha3);
      run({6'h1b, 8'hff}, 8'h00, 8'h00);
      run({5'h08, 3'h7, 6'h3f}, 8'hc7, 8'h00);
      run({5'h09, 3'h7, 6'h00}, 8'h0a, 8'h00);
      run({5'h0a, 3'h0, 6'h11}, 8'hfe, 8'h12);
      run({6'h07, 1'b0, 7'h11}, 8'h33, 8'h44);
      run({5'h0a, 3'h1, 6'h11}, 8'h02, 8'h12);
      run({6'h1b, 8'h0f}, 8'h00, 8'h3c);
      rd_chk(BBIE_OFF_INSTR, {18'h0, 6'h1b, 8'h0f}, "instr");
      // Status is writable and can arm a skip by itself; bits above the field read 0.
      bus(1'b1, BBIE_OFF_STATUS, 32'hffff_fff9);
      {m_skip, m_z, m_h, m_c} = 4'h9;
      rd_chk(BBIE_OFF_STATUS, 32'h0000_0009, "status_wr");
      run({6'h07, 1'b0, 7'h21}, 8'h10, 8'h20);
      bus(1'b1, BBIE_OFF_FADDR, 32'hffff_ffa5);
      rd_chk(BBIE_OFF_FADDR, 32'h0000_0025, "faddr");
      for (int i = 0; i < 250; i++) begin
         rng = xs(rng);
         case (rng[2:0])
            3'h0: op = {6'h07, rng[15:8]};
            3'h1: op = {6'h05, rng[15:8]};
            3'h2: op = {6'h1b, rng[15:8]};
            3'h3: op = {5'h08, rng[16:8]};
            3'h4: op = {5'h09, rng[16:8]};
            3'h5: op = {5'h0a, rng[16:8]};
            default: op = 14'h0000;
         endcase
         run(op, rng[31:24], rng[23:16]);
      end
      end_sim();
   end

endmodule : bbie_core_test
